// ==== design/pcg_pkg.sv ====
// Purpose: Constants and types for the peripheral clock gating block
// Assumes: 32-bit register bus, byte offsets from the block base
// Notes:   Unit index order is fixed by the unit position constants

package pcg_pkg;

   // Register byte offsets
   localparam logic [11:0] OFF_RUN0  = 12'h100;
   localparam logic [11:0] OFF_RUN1  = 12'h104;
   localparam logic [11:0] OFF_SLP0  = 12'h110;
   localparam logic [11:0] OFF_SLP1  = 12'h114;
   localparam logic [11:0] OFF_DSL0  = 12'h120;
   localparam logic [11:0] OFF_DSL1  = 12'h124;
   localparam logic [11:0] OFF_CFG   = 12'h060;
   localparam logic [11:0] OFF_STAT  = 12'h130;
   localparam int          OFF_W     = 12;

   // Group zero fields
   localparam int BIT_WDOG  = 3;
   localparam int BIT_HIBER = 6;
   localparam int BIT_ADC0  = 16;
   // Group one fields
   localparam int BIT_UART0  = 0;
   localparam int BIT_SSER0  = 4;
   localparam int BIT_I2C0   = 12;
   localparam int BIT_I2C1   = 14;
   localparam int BIT_GPT0   = 16;
   // Configuration field
   localparam int BIT_AUTO_GATE = 27;

   localparam logic [31:0] MASK_GRP0  = 32'h0001_0048;
   localparam logic [31:0] MASK_GRP1  = 32'h000F_5017;
   localparam logic [31:0] RESET_GRP0 = 32'h0000_0040;
   localparam logic [31:0] RESET_GRP1 = 32'h0000_0000;

   // Unit positions on the gated clock vector
   localparam int U_WDOG   = 0;
   localparam int U_HIBER  = 1;
   localparam int U_ADC0   = 2;
   localparam int U_UART0  = 3;
   localparam int U_SSER0  = 6;
   localparam int U_I2C0   = 7;
   localparam int U_I2C1   = 8;
   localparam int U_GPT0   = 9;
   localparam int UNITS    = 13;
   localparam logic [UNITS-1:0] RESET_UNITS = 13'h0002;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Power state, Gray along run, sleep, deep sleep
   typedef enum logic [1:0] {
      PWR_RUN   = 2'h0,
      PWR_SLEEP = 2'h1,
      PWR_DEEP  = 2'h3
   } pcg_pwr_t;

   typedef enum logic [3:0] {
      REG_NONE, REG_RUN0, REG_RUN1, REG_SLP0, REG_SLP1,
      REG_DSL0, REG_DSL1, REG_CFG, REG_STAT
   } pcg_reg_t;

endpackage

// ==== design/pcg_clock_gate.sv ====
// Purpose: Glitch-free clock gate cells, one per unit
// Assumes: Enables come from flip-flops on the same clock
// Notes:   Enable is latched while the clock is low

`timescale 1ns/1ns

module pcg_clock_gate #(
   parameter int N = 13
) (
   input  wire logic         clock,       // Source clock
   input  wire logic [N-1:0] enable,      // Per-unit enable
   output logic      [N-1:0] gated_clock  // Per-unit clock
);

   logic [N-1:0] en_latch;

   if (N < 1) begin : g_check
      $error("pcg_clock_gate: N must be at least 1");
   end

   always_latch begin
      if (!clock) begin
         en_latch = enable;
      end
   end

   assign gated_clock = {N{clock}} & en_latch;

endmodule

// ==== design/pcg_peripheral_clock_gating.sv ====
// Purpose: Peripheral clock gating registers and gated clocks
// Assumes: power_state and unit access come from the clock domain
// Notes:   AXI4-Lite slave, one write and one read at a time

`timescale 1ns/1ns

module pcg_peripheral_clock_gating
   import pcg_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic              clock,          // System clock
   input  wire logic              rst_n,          // Async reset
   input  wire logic              clk_en,         // Freezes state
   input  wire logic [1:0]        power_state,    // Current power state
   input  wire logic              unit_access,    // Unit access request
   input  wire logic [3:0]        unit_id,        // Unit being accessed
   output logic                   unit_grant,     // Access allowed
   output logic                   unit_fault,     // Access faulted
   output logic      [UNITS-1:0]  unit_clock,     // Gated unit clocks
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // Write address
   input  wire logic              s_axi_awvalid,  // Write addr valid
   output logic                   s_axi_awready,  // Write addr ready
   input  wire logic [31:0]       s_axi_wdata,    // Write data
   input  wire logic [3:0]        s_axi_wstrb,    // Byte strobes
   input  wire logic              s_axi_wvalid,   // Write data valid
   output logic                   s_axi_wready,   // Write data ready
   output logic      [1:0]        s_axi_bresp,    // Write response
   output logic                   s_axi_bvalid,   // Response valid
   input  wire logic              s_axi_bready,   // Response ready
   input  wire logic [ADDR_W-1:0] s_axi_araddr,   // Read address
   input  wire logic              s_axi_arvalid,  // Read addr valid
   output logic                   s_axi_arready,  // Read addr ready
   output logic      [31:0]       s_axi_rdata,    // Read data
   output logic      [1:0]        s_axi_rresp,    // Read response
   output logic                   s_axi_rvalid,   // Read data valid
   input  wire logic              s_axi_rready    // Read data ready
);

   if (ADDR_W < OFF_W) begin : g_check
      $error("pcg_peripheral_clock_gating: ADDR_W below 12");
   end

   function automatic pcg_reg_t decode(input logic [ADDR_W-1:0] a);
      logic [OFF_W-1:0] lo;
      lo = a[OFF_W-1:0];
      if ((a >> OFF_W) != '0) return REG_NONE;
      case (lo)
         OFF_RUN0: return REG_RUN0;
         OFF_RUN1: return REG_RUN1;
         OFF_SLP0: return REG_SLP0;
         OFF_SLP1: return REG_SLP1;
         OFF_DSL0: return REG_DSL0;
         OFF_DSL1: return REG_DSL1;
         OFF_CFG:  return REG_CFG;
         OFF_STAT: return REG_STAT;
         default:  return REG_NONE;
      endcase
   endfunction

   function automatic logic [31:0] update(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb,
      input logic [31:0] mask);
      logic [31:0] bm;
      bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return ((old & ~bm) | (data & bm)) & mask;
   endfunction

   function automatic logic [UNITS-1:0] units(input logic [31:0] g0,
      input logic [31:0] g1);
      logic [UNITS-1:0] u;
      u = '0;
      u[U_WDOG]  = g0[BIT_WDOG];
      u[U_HIBER] = g0[BIT_HIBER];
      u[U_ADC0]  = g0[BIT_ADC0];
      u[U_UART0+2:U_UART0]   = g1[BIT_UART0+2:BIT_UART0];
      u[U_SSER0]             = g1[BIT_SSER0];
      u[U_I2C0]              = g1[BIT_I2C0];
      u[U_I2C1]              = g1[BIT_I2C1];
      u[U_GPT0+3:U_GPT0]     = g1[BIT_GPT0+3:BIT_GPT0];
      return u;
   endfunction

   logic [31:0]       run0, run1, slp0, slp1, dsl0, dsl1;
   logic [31:0]       next_run0, next_run1, next_slp0, next_slp1;
   logic [31:0]       next_dsl0, next_dsl1;
   logic              auto_gate, next_auto_gate;
   logic              aw_held, next_aw_held, w_held, next_w_held;
   logic [ADDR_W-1:0] awaddr_q, next_awaddr_q;
   logic [31:0]       wdata_q, next_wdata_q;
   logic [3:0]        wstrb_q, next_wstrb_q;
   logic              next_awready, next_wready, next_bvalid;
   logic [1:0]        next_bresp, next_rresp;
   logic              next_arready, next_rvalid;
   logic [31:0]       next_rdata;
   pcg_reg_t          rd_reg, next_rd_reg;
   logic              wr_fire;
   logic [31:0]       bm_cfg;

   logic [UNITS-1:0]  gate_en, next_gate_en;
   logic              next_grant, next_fault;
   logic [31:0]       sel0, sel1;
   pcg_pwr_t          pwr;

   assign pwr = pcg_pwr_t'(power_state);
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;

   // Register bus and register file
   always_comb begin
      next_run0 = run0;
      next_run1 = run1;
      next_slp0 = slp0;
      next_slp1 = slp1;
      next_dsl0 = dsl0;
      next_dsl1 = dsl1;
      next_auto_gate = auto_gate;
      next_aw_held = aw_held;
      next_awaddr_q = awaddr_q;
      next_w_held = w_held;
      next_wdata_q = wdata_q;
      next_wstrb_q = wstrb_q;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      next_rd_reg = rd_reg;
      bm_cfg = update(32'h0000_0000, wdata_q, wstrb_q, 32'hFFFF_FFFF);
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_awaddr_q = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_wdata_q = s_axi_wdata;
         next_wstrb_q = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         case (decode(awaddr_q))
            REG_RUN0: next_run0 = update(run0, wdata_q, wstrb_q, MASK_GRP0);
            REG_RUN1: next_run1 = update(run1, wdata_q, wstrb_q, MASK_GRP1);
            REG_SLP0: next_slp0 = update(slp0, wdata_q, wstrb_q, MASK_GRP0);
            REG_SLP1: next_slp1 = update(slp1, wdata_q, wstrb_q, MASK_GRP1);
            REG_DSL0: next_dsl0 = update(dsl0, wdata_q, wstrb_q, MASK_GRP0);
            REG_DSL1: next_dsl1 = update(dsl1, wdata_q, wstrb_q, MASK_GRP1);
            REG_CFG: begin
               if (wstrb_q[BIT_AUTO_GATE/8]) begin
                  next_auto_gate = bm_cfg[BIT_AUTO_GATE];
               end
            end
            REG_STAT: next_bresp = RESP_OKAY;
            default:  next_bresp = RESP_SLVERR;
         endcase
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         next_rd_reg = decode(s_axi_araddr);
         case (next_rd_reg)
            REG_RUN0: next_rdata = run0;
            REG_RUN1: next_rdata = run1;
            REG_SLP0: next_rdata = slp0;
            REG_SLP1: next_rdata = slp1;
            REG_DSL0: next_rdata = dsl0;
            REG_DSL1: next_rdata = dsl1;
            REG_CFG:  next_rdata = 32'(auto_gate) << BIT_AUTO_GATE;
            REG_STAT: next_rdata = 32'(gate_en);
            default: begin
               next_rdata = 32'h0000_0000;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
      next_arready = !next_rvalid;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         run0 <= RESET_GRP0;
         run1 <= RESET_GRP1;
         slp0 <= RESET_GRP0;
         slp1 <= RESET_GRP1;
         dsl0 <= RESET_GRP0;
         dsl1 <= RESET_GRP1;
         auto_gate <= 1'b0;
         aw_held <= 1'b0;
         awaddr_q <= '0;
         w_held <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
         rd_reg <= REG_NONE;
      end else if (clk_en) begin
         run0 <= next_run0;
         run1 <= next_run1;
         slp0 <= next_slp0;
         slp1 <= next_slp1;
         dsl0 <= next_dsl0;
         dsl1 <= next_dsl1;
         auto_gate <= next_auto_gate;
         aw_held <= next_aw_held;
         awaddr_q <= next_awaddr_q;
         w_held <= next_w_held;
         wdata_q <= next_wdata_q;
         wstrb_q <= next_wstrb_q;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
         rd_reg <= next_rd_reg;
      end
   end

   // Gate selection and access checking
   always_comb begin
      sel0 = run0;
      sel1 = run1;
      if (auto_gate && pwr == PWR_SLEEP) begin
         sel0 = slp0;
         sel1 = slp1;
      end else if (auto_gate && pwr == PWR_DEEP) begin
         sel0 = dsl0;
         sel1 = dsl1;
      end
      next_gate_en = units(sel0, sel1);
      next_grant = 1'b0;
      next_fault = 1'b0;
      if (unit_access) begin
         if (int'(unit_id) < UNITS && gate_en[unit_id]) begin
            next_grant = 1'b1;
         end else begin
            next_fault = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gate_en <= RESET_UNITS;
         unit_grant <= 1'b0;
         unit_fault <= 1'b0;
      end else if (clk_en) begin
         gate_en <= next_gate_en;
         unit_grant <= next_grant;
         unit_fault <= next_fault;
      end
   end

   pcg_clock_gate #(
      .N(UNITS)
   ) u_gate (
      .clock       (clock),
      .enable      (gate_en),
      .gated_clock (unit_clock)
   );

   // Checks
   logic boot;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         boot <= 1'b1;
      end else begin
         boot <= 1'b0;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_reset_vals;
      boot |-> dsl0 == 32'h0000_0040 && run1 == 32'h0 && !auto_gate
         && gate_en == RESET_UNITS;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("register reset values wrong");

   property p_run_apply;
      (!auto_gate && clk_en) |=> gate_en == units($past(run0), $past(run1));
   endproperty
   a_run_apply: assert property (p_run_apply)
      else $error("run set not applied");

   property p_deep_apply;
      (auto_gate && pwr == PWR_DEEP && clk_en)
         |=> gate_en == units($past(dsl0), $past(dsl1));
   endproperty
   a_deep_apply: assert property (p_deep_apply)
      else $error("deep sleep set not applied");

   property p_no_auto_gate;
      (!auto_gate && pwr == PWR_SLEEP && clk_en)
         |=> gate_en[U_I2C1] == $past(run1[BIT_I2C1]);
   endproperty
   a_no_auto_gate: assert property (p_no_auto_gate)
      else $error("sleep set used without auto gating");

   property p_fault;
      (unit_access && unit_id == 4'(U_WDOG) && !gate_en[U_WDOG] && clk_en)
         |=> unit_fault && !unit_grant;
   endproperty
   a_fault: assert property (p_fault)
      else $error("no fault on unclocked access");

   property p_reserved;
      (s_axi_rvalid && rd_reg == REG_DSL0) |-> (s_axi_rdata & ~MASK_GRP0) == 0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bits read nonzero");

   property p_timer_write;
      (wr_fire && clk_en && decode(awaddr_q) == REG_RUN1 && wstrb_q[2])
         |=> run1[19:16] == $past(wdata_q[19:16]) && s_axi_bvalid;
   endproperty
   a_timer_write: assert property (p_timer_write)
      else $error("timer enables not written");

   property p_deep_write;
      (wr_fire && clk_en && decode(awaddr_q) == REG_DSL0 && wstrb_q == 4'hF)
         |=> dsl0 == ($past(wdata_q) & 32'h0001_0048);
   endproperty
   a_deep_write: assert property (p_deep_write)
      else $error("deep sleep group zero write wrong");

endmodule

// ==== bench/pcg_unit_model.sv ====
// Purpose: Passive model of the units fed by the gated clocks
// Assumes: One gated clock per unit, source clock on clock
// Notes:   Counts unit clock edges and flags any truncated pulse

`timescale 1ns/1ns

module pcg_unit_model
   import pcg_pkg::*;
(
   input  wire logic             clock,         // Source clock
   input  wire logic             clear,         // Clears counts and flags
   input  wire logic [UNITS-1:0] unit_clock,    // Gated unit clocks
   output logic      [7:0]       ticks [UNITS], // Edges seen per unit
   output logic                  runt           // Truncated pulse seen
);
   logic [UNITS-1:0] bad;

   assign runt = |bad;

   for (genvar i = 0; i < UNITS; i++) begin : g_unit
      always @(posedge unit_clock[i] or posedge clear) begin
         if (clear)
            ticks[i] <= 8'h00;
         else if (ticks[i] != 8'hFF)
            ticks[i] <= ticks[i] + 8'h01;
      end
      always @(unit_clock[i] or posedge clear) begin
         if (clear)
            bad[i] <= 1'h0;
         else if (unit_clock[i] !== clock)
            bad[i] <= 1'h1;
      end
   end
endmodule

// ==== bench/pcg_peripheral_clock_gating_test.sv ====
// Purpose: Self-checking bench for the peripheral clock gating block
// Assumes: AXI4-Lite master tasks, unit model on the gated clocks
// Notes:   Table loop covers reset values and writable masks

`timescale 1ns/1ns

module pcg_peripheral_clock_gating_test;
   import pcg_pkg::*;

   typedef struct packed {
      logic [11:0] a;
      logic [31:0] e0;
      logic [31:0] d;
      logic [31:0] e;
   } pcg_row_t;

   logic             clock, rst_n, clk_en, unit_access, clear;
   logic [1:0]       power_state, bresp, rresp, rs;
   logic [3:0]       unit_id, wstrb;
   logic             unit_grant, unit_fault, runt;
   logic [UNITS-1:0] unit_clock;
   logic [11:0]      awaddr, araddr;
   logic [31:0]      wdata, rdata, rd;
   logic             awvalid, awready, wvalid, wready, bvalid, bready;
   logic             arvalid, arready, rvalid, rready;
   logic [7:0]       ticks [UNITS];
   int               err_total, samples_checked;
   pcg_row_t         rows [6];

   pcg_peripheral_clock_gating dut (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .power_state(power_state), .unit_access(unit_access),
      .unit_id(unit_id), .unit_grant(unit_grant),
      .unit_fault(unit_fault), .unit_clock(unit_clock),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));

   pcg_unit_model units (
      .clock(clock), .clear(clear), .unit_clock(unit_clock),
      .ticks(ticks), .runt(runt));

   task automatic test_done;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clock);
         n++;
         if (awvalid && awready)
            awvalid <= 1'h0;
         if (wvalid && wready)
            wvalid <= 1'h0;
      end while (!(bvalid === 1'h1) && n < 50);
      rs = bresp;
      bready <= 1'h0;
      chk("write wait", 32'h0, 32'(n >= 50));
   endtask

   task automatic rdv(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clock);
         n++;
         if (arvalid && arready)
            arvalid <= 1'h0;
      end while (!(rvalid === 1'h1) && n < 50);
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
      chk("read wait", 32'h0, 32'(n >= 50));
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      rdv(a);
      chk("rdata", e, rd);
      chk("rresp", 32'(RESP_OKAY), 32'(rs));
   endtask

   // Unit access, answer sampled one cycle after it is taken
   task automatic acc(input int u, input logic g);
      @(posedge clock);
      unit_access <= 1'h1;
      unit_id <= 4'(u);
      @(posedge clock);
      unit_access <= 1'h0;
      @(posedge clock);
      chk("unit_grant", 32'(g), 32'(unit_grant));
      chk("unit_fault", 32'(!g), 32'(unit_fault));
   endtask

   task automatic tick(input int u, input logic on);
      @(posedge clock);
      clear <= 1'h1;
      @(posedge clock);
      clear <= 1'h0;
      repeat (8) @(posedge clock);
      chk("unit_clock", 32'(on), 32'(ticks[u] != 8'h00));
   endtask

   task automatic pwr(input pcg_pwr_t p);
      @(posedge clock);
      power_state <= p;
      repeat (3) @(posedge clock);
   endtask

   initial begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end

   initial begin
      #100000;
      err_total++;
      test_done;
   end

   initial begin
      rows = '{'{OFF_RUN0, RESET_GRP0, 32'hFFFF_FFFF, MASK_GRP0},
               '{OFF_RUN1, RESET_GRP1, 32'hFFFF_FFFF, MASK_GRP1},
               '{OFF_SLP0, RESET_GRP0, 32'hFFFF_FFFF, MASK_GRP0},
               '{OFF_SLP1, RESET_GRP1, 32'hFFFF_FFFF, MASK_GRP1},
               '{OFF_DSL0, RESET_GRP0, 32'hFFFF_FFFF, MASK_GRP0},
               '{OFF_DSL1, RESET_GRP1, 32'hFFFF_FFFF, MASK_GRP1}};
      {rst_n, unit_access, clear, awvalid, wvalid, bready} = 6'h00;
      {arvalid, rready} = 2'h0;
      clk_en = 1'h1;
      power_state = PWR_RUN;
      unit_id = 4'h0;
      {awaddr, araddr, wstrb} = 28'h0;
      wdata = 32'h0;
      err_total = 0;
      samples_checked = 0;
      repeat (3) @(posedge clock);
      rst_n <= 1'h1;
      clear <= 1'h1;
      @(posedge clock);
      clear <= 1'h0;
      foreach (rows[i]) begin
         rchk(rows[i].a, rows[i].e0);
         wr(rows[i].a, rows[i].d, 4'hF);
         rchk(rows[i].a, rows[i].e);
      end
      // Unmapped address is refused on both paths
      wr(12'h200, 32'hFFFF_FFFF, 4'hF);
      chk("bresp", 32'(RESP_SLVERR), 32'(rs));
      rdv(12'h200);
      chk("rdata", 32'h0, rd);
      chk("rresp", 32'(RESP_SLVERR), 32'(rs));
      // Only the strobed byte lands
      wr(OFF_RUN1, 32'h0, 4'hF);
      wr(OFF_RUN1, 32'hFFFF_FFFF, 4'h4);
      rchk(OFF_RUN1, 32'h000F_0000);
      wr(OFF_RUN0, 32'h40, 4'hF);
      acc(U_WDOG, 1'h0);
      acc(U_HIBER, 1'h1);
      acc(U_GPT0 + 3, 1'h1);
      acc(U_UART0, 1'h0);
      acc(13, 1'h0);
      tick(U_HIBER, 1'h1);
      tick(U_WDOG, 1'h0);
      wr(OFF_RUN0, 32'h8, 4'hF);
      wr(OFF_SLP0, 32'h0001_0000, 4'hF);
      wr(OFF_DSL0, 32'h40, 4'hF);
      pwr(PWR_SLEEP);
      acc(U_WDOG, 1'h1);
      wr(OFF_CFG, 32'h0800_0000, 4'hF);
      acc(U_ADC0, 1'h1);
      acc(U_WDOG, 1'h0);
      rchk(OFF_STAT, 32'h1FFC);
      tick(U_ADC0, 1'h1);
      pwr(PWR_DEEP);
      acc(U_HIBER, 1'h1);
      acc(U_ADC0, 1'h0);
      pwr(PWR_RUN);
      acc(U_WDOG, 1'h1);
      chk("runt", 32'h0, 32'(runt));
      // Clock enable low freezes the access answer
      @(posedge clock);
      clk_en <= 1'h0;
      unit_access <= 1'h1;
      unit_id <= 4'(U_WDOG);
      @(posedge clock);
      unit_access <= 1'h0;
      @(posedge clock);
      chk("frozen grant", 32'h0, 32'(unit_grant));
      clk_en <= 1'h1;
      // Second reset in mid-run restores defaults
      @(posedge clock);
      rst_n <= 1'h0;
      repeat (2) @(posedge clock);
      rst_n <= 1'h1;
      @(posedge clock);
      rchk(OFF_RUN1, RESET_GRP1);
      rchk(OFF_DSL0, RESET_GRP0);
      acc(U_HIBER, 1'h1);
      acc(U_WDOG, 1'h0);
      test_done;
   end
endmodule
